/* design/spi_fram_slave.v */
// Summary of operation
// - chip select high: standby, ignore inputs, output off
// - serial clock acts only while selected
// - sample input on rising, launch output on falling
// - any clock rate to 20 MHz, stops allowed
// - output driven only for read data and status, off in pause
// - protect pin enable with write protect low blocks status writes
// - pause low freezes operation, ignores clock and select
// - each written byte commits at once, no busy
// - memory is 2048 byte locations
// - modes 0 and 3 both work
// - block protect upper quarter, half or all
// - first byte after select is the command
// - all fields shifted most significant bit first
// - two address bytes, low 11 bits used
// - unknown command ignores rest, output stays off
`include "spi_fram_defines.vh"

module spi_fram_slave #(
  parameter ADDR_W = 11,
  parameter DATA_W = 8,
  parameter FIFO_AW = 1,
  parameter FIFO_DEPTH = 2
) (
  // clock, reset, enable
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire CE_I,
  // serial link pins
  input wire SPI_CS_N_I,
  input wire SPI_SCK_I,
  input wire SPI_SI_I,
  input wire SPI_HOLD_N_I,
  input wire SPI_WP_N_I,
  output wire SPI_SO_O,
  output wire SPI_SO_OE_N_O
);

  localparam MEM_DEPTH = 1 << ADDR_W;
  localparam FIFO_W = ADDR_W + DATA_W;

  localparam ST_CMD = 4'h0;
  localparam ST_ADDR_HI = 4'h1;
  localparam ST_ADDR_LO = 4'h2;
  localparam ST_WDATA = 4'h3;
  localparam ST_RDATA = 4'h4;
  localparam ST_SR_WR = 4'h5;
  localparam ST_SR_RD = 4'h6;
  localparam ST_DONE = 4'h7;
  localparam ST_IGNORE = 4'h8;

  // input synchronisers, first stage read only by the second
  reg cs_m_r, cs_s_r;
  reg sck_m_r, sck_s_r;
  reg si_m_r, si_s_r;
  reg hold_m_r, hold_s_r;
  reg wp_m_r, wp_s_r;

  // engine state
  reg sck_p_r, cs_p_r;
  reg [3:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [DATA_W-1:0] shift_r;
  reg [ADDR_W-1:0] addr_r;
  reg [DATA_W-1:0] status_r;
  reg [DATA_W-1:0] out_byte_r;
  reg is_read_r;
  reg wr_cmd_r;
  reg drive_r;
  reg so_r;
  reg oe_n_r;

  // memory array and write buffer
  reg [DATA_W-1:0] mem [0:MEM_DEPTH-1];
  reg [FIFO_W-1:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW-1:0] fifo_wr_r;
  reg [FIFO_AW-1:0] fifo_rd_r;
  reg [FIFO_AW:0] fifo_cnt_r;

  wire selected;
  wire held;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire last_bit;
  wire [DATA_W-1:0] rx_byte;
  wire [1:0] bp;
  wire wel;
  wire sr_locked;
  reg addr_locked;
  wire push_req;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_push;
  wire fifo_pop;
  wire stall;
  wire run;
  wire fetch;
  wire [FIFO_W-1:0] fifo_head;
  wire [ADDR_W-1:0] next_addr;
  wire [ADDR_W-1:0] lo_addr;

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      si_m_r <= 1'b0;
      si_s_r <= 1'b0;
      hold_m_r <= 1'b1;
      hold_s_r <= 1'b1;
      wp_m_r <= 1'b1;
      wp_s_r <= 1'b1;
    end else if (CE_I) begin
      // link clock sampled here; 20 MHz leaves at least 3 samples a phase
      cs_m_r <= SPI_CS_N_I;
      cs_s_r <= cs_m_r;
      sck_m_r <= SPI_SCK_I;
      sck_s_r <= sck_m_r;
      si_m_r <= SPI_SI_I;
      si_s_r <= si_m_r;
      hold_m_r <= SPI_HOLD_N_I;
      hold_s_r <= hold_m_r;
      wp_m_r <= SPI_WP_N_I;
      wp_s_r <= wp_m_r;
    end
  end

  assign selected = ~cs_s_r;
  assign held = ~hold_s_r;
  // edges only counted while selected, so clock is gated by select
  assign sck_rise = selected & sck_s_r & ~sck_p_r;
  assign sck_fall = selected & ~sck_s_r & sck_p_r;
  assign cs_rise = cs_s_r & ~cs_p_r;
  assign last_bit = (bit_cnt_r == `LAST_BIT);
  assign rx_byte = {shift_r[DATA_W-2:0], si_s_r};
  assign bp = {status_r[`SR_BP_HI_BIT], status_r[`SR_BP_LO_BIT]};
  assign wel = status_r[`SR_WEL_BIT];
  assign sr_locked = status_r[`SR_PPE_BIT] & ~wp_s_r;
  assign next_addr = addr_r + 1'b1;
  assign lo_addr = {addr_r[ADDR_W-1:DATA_W], rx_byte};

  always @* begin
    case (bp)
      `BP_QUARTER: addr_locked = (addr_r >= `QUARTER_BASE);
      `BP_HALF: addr_locked = (addr_r >= `HALF_BASE);
      `BP_ALL: addr_locked = 1'b1;
      default: addr_locked = 1'b0;
    endcase
  end

  // a completed data byte goes straight into the write buffer when write enabled and not protected
  assign push_req = CE_I & ~held & sck_rise & last_bit &
    (state_r == ST_WDATA) & wel & ~addr_locked;
  // full buffer holds the edge pending instead of losing the byte
  assign stall = push_req & ~fifo_in_ready;
  assign run = CE_I & ~held & ~stall;
  assign fifo_push = push_req & fifo_in_ready;
  // array read port has priority over buffer drain
  assign fetch = run & ((sck_rise & last_bit & is_read_r &
    (state_r == ST_ADDR_LO)) |
    (sck_fall & last_bit & (state_r == ST_RDATA)));

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sck_p_r <= 1'b0;
      cs_p_r <= 1'b1;
      state_r <= ST_CMD;
      bit_cnt_r <= `FIRST_BIT;
      shift_r <= {DATA_W{1'b0}};
      addr_r <= {ADDR_W{1'b0}};
      status_r <= `SR_RESET;
      out_byte_r <= {DATA_W{1'b0}};
      is_read_r <= 1'b0;
      wr_cmd_r <= 1'b0;
      drive_r <= 1'b0;
      so_r <= 1'b0;
    end else if (run) begin
      sck_p_r <= sck_s_r;
      cs_p_r <= cs_s_r;
      if (!selected) begin
        // partial byte and command dropped on deselect
        state_r <= ST_CMD;
        bit_cnt_r <= `FIRST_BIT;
        is_read_r <= 1'b0;
        drive_r <= 1'b0;
        wr_cmd_r <= 1'b0;
        if (cs_rise && wr_cmd_r) begin
          status_r[`SR_WEL_BIT] <= 1'b0;
        end
      end else begin
        if (sck_rise && state_r != ST_IGNORE) begin
          shift_r <= rx_byte;
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
        if (sck_rise && last_bit) begin
          case (state_r)
            ST_CMD: begin
              case (rx_byte)
                `OP_WREN: begin
                  status_r[`SR_WEL_BIT] <= 1'b1;
                  state_r <= ST_DONE;
                end
                `OP_WRDI: begin
                  status_r[`SR_WEL_BIT] <= 1'b0;
                  state_r <= ST_DONE;
                end
                `OP_RDSR: begin
                  out_byte_r <= status_r;
                  state_r <= ST_SR_RD;
                end
                `OP_WRSR: begin
                  wr_cmd_r <= 1'b1;
                  state_r <= ST_SR_WR;
                end
                `OP_READ: begin
                  is_read_r <= 1'b1;
                  state_r <= ST_ADDR_HI;
                end
                `OP_WRITE: begin
                  wr_cmd_r <= 1'b1;
                  state_r <= ST_ADDR_HI;
                end
                default: begin
                  state_r <= ST_IGNORE;
                end
              endcase
            end
            ST_ADDR_HI: begin
              // upper five address bits are don't care
              addr_r[ADDR_W-1:DATA_W] <=
                rx_byte[`ADDR_HI_MSB:`ADDR_HI_LSB];
              state_r <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              addr_r <= lo_addr;
              if (is_read_r) begin
                out_byte_r <= mem[lo_addr];
                state_r <= ST_RDATA;
              end else begin
                state_r <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              addr_r <= next_addr;
            end
            ST_SR_WR: begin
              if (wel && !sr_locked) begin
                status_r <= (status_r & ~`SR_WMASK) |
                  (rx_byte & `SR_WMASK);
              end
              state_r <= ST_DONE;
            end
            default: begin
            end
          endcase
        end
        if (sck_fall && (state_r == ST_RDATA || state_r == ST_SR_RD)) begin
          so_r <= out_byte_r[DATA_W-1];
          drive_r <= 1'b1;
          if (last_bit) begin
            if (state_r == ST_RDATA) begin
              addr_r <= next_addr;
              out_byte_r <= mem[next_addr];
            end else begin
              out_byte_r <= status_r;
            end
          end else begin
            out_byte_r <= {out_byte_r[DATA_W-2:0], 1'b0};
          end
        end
      end
    end
  end

  // output enable also answers pause, which freezes the engine
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      oe_n_r <= 1'b1;
    end else if (CE_I) begin
      oe_n_r <= ~(drive_r & selected & ~held);
    end
  end

  // two-entry write buffer
  assign fifo_in_ready = (fifo_cnt_r != FIFO_DEPTH[FIFO_AW:0]);
  assign fifo_out_valid = (fifo_cnt_r != {(FIFO_AW+1){1'b0}});
  assign fifo_pop = CE_I & fifo_out_valid & ~fetch;
  assign fifo_head = fifo_mem[fifo_rd_r];

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fifo_wr_r <= {FIFO_AW{1'b0}};
      fifo_rd_r <= {FIFO_AW{1'b0}};
      fifo_cnt_r <= {(FIFO_AW+1){1'b0}};
    end else if (CE_I) begin
      if (fifo_push) begin
        fifo_wr_r <= fifo_wr_r + 1'b1;
      end
      if (fifo_pop) begin
        fifo_rd_r <= fifo_rd_r + 1'b1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt_r <= fifo_cnt_r + 1'b1;
      end else if (!fifo_push && fifo_pop) begin
        fifo_cnt_r <= fifo_cnt_r - 1'b1;
      end
    end
  end

  // array has no reset: its contents are the stored data
  always @(posedge REF_CLK_I) begin
    if (fifo_push) begin
      fifo_mem[fifo_wr_r] <= {addr_r, rx_byte};
    end
    if (fifo_pop) begin
      mem[fifo_head[FIFO_W-1:DATA_W]] <= fifo_head[DATA_W-1:0];
    end
  end

  assign SPI_SO_O = so_r;
  assign SPI_SO_OE_N_O = oe_n_r;

endmodule // spi_fram_slave

/* common/spi_fram_defines.vh */
`ifndef SPI_FRAM_DEFINES_VH
`define SPI_FRAM_DEFINES_VH

// command bytes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_READ 8'h03
`define OP_WRITE 8'h02

// status register layout
`define SR_PPE_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_WEL_BIT 1
`define SR_WMASK 8'h8C
`define SR_RESET 8'h00

// block protect codes and region bases
`define BP_NONE 2'b00
`define BP_QUARTER 2'b01
`define BP_HALF 2'b10
`define BP_ALL 2'b11
`define QUARTER_BASE 11'h600
`define HALF_BASE 11'h400

// address handling
`define ADDR_HI_LSB 0
`define ADDR_HI_MSB 2
`define LAST_BIT 3'h7
`define FIRST_BIT 3'h0

// serial clock limit against the sampling clock
`define SCK_MAX_MHZ 20
`define REF_MHZ 125

`endif

/* tb/spi_fram_slave_sva.sv */
module spi_fram_slave_chk (
  // clock and reset
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire CE_I,
  // link pins
  input wire SPI_CS_N_I,
  input wire SPI_SCK_I,
  input wire SPI_SI_I,
  input wire SPI_HOLD_N_I,
  input wire SPI_WP_N_I,
  input wire SPI_SO_O,
  input wire SPI_SO_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  a_idle_quiet: assert property (SPI_CS_N_I [*5] |-> SPI_SO_OE_N_O)
    else $error("output driven while deselected");
  a_cs_off: assert property ($rose(SPI_CS_N_I) |-> ##[1:5] SPI_SO_OE_N_O)
    else $error("output not released after deselect");
  a_gate_cs: assert property (!SPI_SO_OE_N_O |-> !$past(SPI_CS_N_I, 5))
    else $error("output driven without select");
  a_so_launch: assert property
    (!SPI_SO_OE_N_O && $changed(SPI_SO_O) |-> !$past(SPI_SCK_I, 2))
    else $error("output changed away from falling clock");
  a_so_steady: assert property
    (SPI_SCK_I [*4] ##1 !SPI_SO_OE_N_O |-> $stable(SPI_SO_O))
    else $error("output moved while clock high");
  a_oe_start: assert property ($fell(SPI_SO_OE_N_O) |->
    !$past(SPI_SCK_I, 2) && !$past(SPI_CS_N_I, 3))
    else $error("drive began off a falling clock");
  a_pause_quiet: assert property (!SPI_HOLD_N_I [*5] |-> SPI_SO_OE_N_O)
    else $error("output driven during pause");
  a_pause_off: assert property ($fell(SPI_HOLD_N_I) |-> ##[1:5] SPI_SO_OE_N_O)
    else $error("output not released at pause");
  a_pause_frozen: assert property (!SPI_HOLD_N_I [*4] |-> $stable(SPI_SO_O))
    else $error("output moved during pause");
endmodule // spi_fram_slave_chk

bind spi_fram_slave spi_fram_slave_chk chk (.REF_CLK_I(REF_CLK_I),
  .RESET_I(RESET_I), .CE_I(CE_I), .SPI_CS_N_I(SPI_CS_N_I),
  .SPI_SCK_I(SPI_SCK_I), .SPI_SI_I(SPI_SI_I), .SPI_HOLD_N_I(SPI_HOLD_N_I),
  .SPI_WP_N_I(SPI_WP_N_I), .SPI_SO_O(SPI_SO_O),
  .SPI_SO_OE_N_O(SPI_SO_OE_N_O));

/* tb/spi_master_model.sv */
module spi_master_model (
  // sampling clock and returned data
  input wire clk,
  input wire so,
  // link pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode3 = 1'b0;
  int nb = 8;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sel();
    cs_n <= 1'b0;
    tick(8);
  endtask
  // idle level picks the mode; data line flips so no stale bit lingers
  task automatic desel();
    sck <= mode3;
    tick(8);
    cs_n <= 1'b1;
    si <= ~si;
    tick(16);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      tick(8);
      sck <= 1'b1;
      rx[i] = so;
      tick(8);
    end
  endtask
  // stray pulses inside the pause must be ignored by the device
  task automatic pause();
    sck <= 1'b0;
    tick(8);
    hold_n <= 1'b0;
    tick(8);
    repeat (2) begin
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
      tick(4);
    end
    hold_n <= 1'b1;
    tick(8);
  endtask
endmodule // spi_master_model

/* tb/tb_top.sv */
`include "spi_fram_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  wire cs_n, sck, si, hold_n, wp_n, so, so_oe_n;
  wire miso;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] r0, r1;
  initial forever #4 ref_clk = ~ref_clk;
  // released line shows the inverse of the last bit, so a late enable shows
  assign miso = so_oe_n ? ~so : so;
  spi_master_model m (.clk(ref_clk), .so(miso), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n));
  spi_fram_slave dut (.REF_CLK_I(ref_clk), .RESET_I(reset), .CE_I(1'b1),
    .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck), .SPI_SI_I(si),
    .SPI_HOLD_N_I(hold_n), .SPI_WP_N_I(wp_n), .SPI_SO_O(so),
    .SPI_SO_OE_N_O(so_oe_n));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    m.sel();
    m.xfer(c, r0);
    m.desel();
  endtask
  task automatic wrsr(input logic [7:0] v);
    op(`OP_WREN);
    m.sel();
    m.xfer(`OP_WRSR, r0);
    m.xfer(v, r0);
    m.desel();
  endtask
  task automatic rdsr(output logic [7:0] s);
    m.sel();
    m.xfer(`OP_RDSR, r0);
    m.xfer(8'h00, s);
    m.desel();
  endtask
  // upper address bits sent as ones to prove they are dropped
  task automatic wr(input logic [10:0] a, input logic [7:0] d0, d1);
    op(`OP_WREN);
    m.sel();
    m.xfer(`OP_WRITE, r0);
    m.xfer({5'h1f, a[10:8]}, r0);
    m.xfer(a[7:0], r0);
    m.xfer(d0, r0);
    m.xfer(d1, r0);
    m.desel();
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d0, d1);
    m.sel();
    m.xfer(`OP_READ, d0);
    m.xfer({5'h00, a[10:8]}, d0);
    m.xfer(a[7:0], d0);
    m.xfer(8'h00, d0);
    m.xfer(8'h00, d1);
    m.desel();
  endtask
  task automatic t_basic();
    chk({7'h00, so_oe_n}, 8'h01);
    rdsr(r0);
    chk(r0, `SR_RESET);
    for (int md = 0; md < 2; md++) begin
      m.mode3 = md[0];
      m.desel();
      wr(11'h7ff, 8'ha5 ^ md[7:0], 8'h3c);
      rd(11'h7ff, r0, r1);
      chk(r0, 8'ha5 ^ md[7:0]);
      chk(r1, 8'h3c);
    end
    m.mode3 = 1'b0;
    m.desel();
    $display("basic access done");
  endtask
  task automatic t_protect();
    logic [10:0] a;
    for (int bp = 1; bp < 4; bp++) begin
      a = (bp == 1) ? `QUARTER_BASE - 11'h001 :
          (bp == 2) ? `HALF_BASE - 11'h001 : 11'h7ff;
      wrsr(8'h00);
      wr(a, 8'h11, 8'h11);
      wrsr({4'h0, bp[1:0], 2'b00});
      wr(a, 8'h22, 8'h22);
      wrsr(8'h00);
      rd(a, r0, r1);
      chk(r0, (bp == 3) ? 8'h11 : 8'h22);
      chk(r1, 8'h11);
    end
    $display("block protect done");
  endtask
  task automatic t_wp();
    wrsr(8'h80);
    m.wp_n <= 1'b0;
    wrsr(8'h0c);
    rdsr(r0);
    chk(r0, 8'h80);
    m.wp_n <= 1'b1;
    wrsr(8'h8c);
    rdsr(r0);
    chk(r0, 8'h8c);
    $display("write protect done");
  endtask
  task automatic t_bad();
    m.sel();
    m.xfer(8'hff, r0);
    m.xfer(`OP_RDSR, r0);
    m.xfer(8'h00, r1);
    chk({7'h00, so_oe_n}, 8'h01);
    m.desel();
    m.nb = 4;
    m.sel();
    m.xfer(8'hff, r0);
    m.desel();
    m.nb = 8;
    rdsr(r0);
    chk(r0, 8'h8c);
    wrsr(8'h00);
    $display("bad command done");
  endtask
  task automatic t_hold();
    wr(11'h010, 8'h5a, 8'hc3);
    m.sel();
    m.xfer(`OP_READ, r0);
    m.xfer(8'h00, r0);
    m.xfer(8'h10, r0);
    m.xfer(8'h00, r0);
    m.pause();
    m.xfer(8'h00, r1);
    m.desel();
    chk(r0, 8'h5a);
    chk(r1, 8'hc3);
    $display("pause done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_basic();
    t_protect();
    t_wp();
    t_bad();
    t_hold();
    final_report();
  end
  // the tests need roughly 160 us
  initial begin
    #400000;
    err_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    final_report();
  end
endmodule // tb_top
